// ---- umc_chan_model.sv ----
`timescale 1ns/100ps
module umc_chan_model
(
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        sys_rst_i,
    // channel activity and processor indications
    input  wire logic        io_busy_i,
    input  wire logic        cpu_running_i,
    input  wire logic        meter_out_i,
    // usage request and own meter
    output logic             meter_in_o,
    output logic [15:0]      unit_time_o
);
    // request only while processor-started i/o is in flight
    assign meter_in_o = io_busy_i;

    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            unit_time_o <= 16'h0000;
        else if (cpu_running_i | meter_out_i)
            unit_time_o <= unit_time_o + 16'h0001;
    end
endmodule

// ---- umc_pkg.sv ----
package umc_pkg;

    // ****************************************
    // timing
    // ****************************************
    localparam int unsigned CLK_HZ     = 40_000_000;
    localparam int unsigned MIN_ON_MS  = 400;
    // least time in whole cycles, kHz truncated, forced to at least one
    localparam int unsigned MIN_ON_CYC =
        (CLK_HZ / 1000 * MIN_ON_MS + 0) > 0 ?
        (CLK_HZ / 1000 * MIN_ON_MS) : 1;
    localparam int          CNT_W      = 24;

    // ****************************************
    // register map (byte addresses)
    // ****************************************
    localparam logic [3:0] CTRL_OFS  = 4'h0;
    localparam logic [3:0] STAT_OFS  = 4'h4;
    localparam logic [3:0] CNT_OFS   = 4'h8;

    localparam int         CTRL_EN   = 0;
    localparam int         CTRL_SC   = 1;
    localparam logic [1:0] CTRL_RST  = 2'h1;

    localparam int         ST_PASS   = 0;
    localparam int         ST_RELAY  = 1;
    localparam int         ST_PROC   = 2;
    localparam int         ST_MAINT  = 3;
    localparam int         ST_RUN    = 4;
    localparam int         ST_SUPP   = 5;
    localparam int         ST_W      = 6;

    // ****************************************
    // pins
    // ****************************************
    localparam int PB_W     = 8;
    localparam int STOP_IDX = 0;

    typedef struct packed {
        logic            key_maint;
        logic            wait_state;
        logic            manual;
        logic            start_op;
        logic            load_op;
        logic            reset_op;
        logic            clk_pulse;
        logic            machine_check;
        logic            initial_program_load;
        logic            check_disable_position;
        logic            stor_hold;
        logic            meter_in;
        logic [PB_W-1:0] pushbutton;
    } umc_pins_s;

    typedef struct packed {
        logic proc_meter;
        logic maint_meter;
        logic meter_drive_relay;
        logic cpu_running;
        logic meter_out;
    } umc_drv_s;

endpackage

// ---- umc_sync.sv ----
`timescale 1ns/100ps
module umc_sync
#(
    parameter int W = 1
)
(
    input  wire logic         clk_i,
    input  wire logic         sys_rst_i,
    input  wire logic         ce_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);

    logic [W-1:0] meta_r;

    // first stage feeds only the second one
    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            meta_r <= '0;
            q_o    <= '0;
        end
        else if (ce_i)
        begin
            meta_r <= d_i;
            q_o    <= meta_r;
        end
    end

endmodule

// ---- umc_top.sv ----
// Notes on behaviour
// - normal key position drives process meter, maintenance position the other
// - meter runs while pass trigger set and (active or channel request)
// - any pushbutton pulses meter, except stop while already manual
// - start, load or reset operation sets the pass trigger
// - single-cycle mode clears pass trigger after one gated pulse
// - machine check suppresses time recording
// - check during program load with check disabled keeps recording
// - outside program load, storage hold switch keeps recording on check
// - running indication unless waiting, manual, or check-suppressed
// - process-time indication while process meter records
// - each meter activation lasts at least 400 ms
// - relay output energised whenever the selected meter runs
//
// Added by the designer: the register offsets and the Wishbone slave port.
`timescale 1ns/100ps
module umc_top
    import umc_pkg::*;
#(
    parameter int unsigned MIN_CYC = MIN_ON_CYC
)
(
    // clock, reset, enable
    input  wire logic               clk_i,
    input  wire logic               sys_rst_i,
    input  wire logic               ce_i,
    // wishbone slave
    input  wire logic               cyc_i,
    input  wire logic               stb_i,
    input  wire logic               we_i,
    input  wire logic [3:0]         adr_i,
    input  wire logic [3:0]         sel_i,
    input  wire logic [31:0]        dat_i,
    output logic      [31:0]        dat_o,
    output logic                    ack_o,
    // console and channel pins
    input  wire umc_pkg::umc_pins_s pins_i,
    // meter and channel drives
    output umc_pkg::umc_drv_s       drv_o
);

    import umc_pkg::*;

    // ****************************************
    // pin synchronisers
    // ****************************************
    localparam int PIN_W = $bits(umc_pins_s);

    logic [PIN_W-1:0] pins_raw;
    logic [PIN_W-1:0] pins_q;
    umc_pins_s        pin;
    umc_pins_s        pin_d_r;

    assign pins_raw = pins_i;
    assign pin      = pins_q;

    umc_sync
    #(
        .W         (PIN_W)
    )
    u_sync
    (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .ce_i      (ce_i),
        .d_i       (pins_raw),
        .q_o       (pins_q)
    );

    // previous synchronised sample for edge detection
    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            pin_d_r <= '0;
        else if (ce_i)
            pin_d_r <= pin;
    end

    // ****************************************
    // state
    // ****************************************
    logic [1:0]       ctrl_r;
    logic             pass_r;
    logic             exempt_r;
    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] cnt_nxt;
    logic             pass_nxt;
    umc_drv_s         drv_nxt;

    // ****************************************
    // pass-pulse trigger
    // ****************************************
    wire op_rise  = (pin.start_op & ~pin_d_r.start_op)
                  | (pin.load_op  & ~pin_d_r.load_op)
                  | (pin.reset_op & ~pin_d_r.reset_op);
    wire trig_set = op_rise;
    wire pulse_up = pin.clk_pulse & ~pin_d_r.clk_pulse;
    wire single   = ctrl_r[CTRL_SC];
    // one gated pulse in single-cycle mode ends the pass
    wire trig_clr = single & pass_r & pulse_up;

    // a set in the clearing cycle wins
    assign pass_nxt = trig_set ? 1'b1 :
                      trig_clr ? 1'b0 : pass_r;

    // ****************************************
    // machine-check handling
    // ****************************************
    wire mchk_rise  = pin.machine_check & ~pin_d_r.machine_check;
    // exemption is judged at the moment the check arrives
    wire exempt_now =
        (pin.initial_program_load & pin.check_disable_position)
      | (~pin.initial_program_load & pin.stor_hold);
    wire exempt     = mchk_rise ? exempt_now : exempt_r;
    wire suppress   = pin.machine_check & ~exempt;

    // ****************************************
    // recording decision
    // ****************************************
    wire active   = ~pin.wait_state & ~pin.manual;
    // channel request keeps the meter going during wait or manual
    wire run_req  = ctrl_r[CTRL_EN] & pass_r
                  & (active | pin.meter_in)
                  & ~suppress;

    wire [PB_W-1:0] pb_rise = pin.pushbutton & ~pin_d_r.pushbutton;
    wire [PB_W-1:0] pb_mask;
    // stop is ignored as a meter event once already manual
    assign pb_mask = pin.manual ?
                     ~(PB_W'(1) << STOP_IDX) : {PB_W{1'b1}};
    wire pb_hit   = ctrl_r[CTRL_EN] & |(pb_rise & pb_mask);

    wire activate = run_req | pb_hit;

    // ****************************************
    // minimum on-time stretch
    // ****************************************
    localparam logic [CNT_W-1:0] RELOAD = CNT_W'(MIN_CYC);

    // reload on each request, so a held request never lets it lapse
    assign cnt_nxt = activate ? RELOAD :
                     (cnt_r != '0) ? cnt_r - CNT_W'(1) : cnt_r;

    wire relay_nxt = (cnt_nxt != '0);

    // ****************************************
    // meter and channel drives
    // ****************************************
    always_comb
    begin
        drv_nxt                   = '0;
        drv_nxt.meter_drive_relay = relay_nxt;
        drv_nxt.proc_meter        = relay_nxt & ~pin.key_maint;
        drv_nxt.maint_meter       = relay_nxt &  pin.key_maint;
        drv_nxt.cpu_running       = active & ~suppress;
        drv_nxt.meter_out         = relay_nxt & ~pin.key_maint;
    end

    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            pass_r   <= 1'b0;
            exempt_r <= 1'b0;
            cnt_r    <= '0;
            drv_o    <= '0;
        end
        else if (ce_i)
        begin
            pass_r   <= pass_nxt;
            cnt_r    <= cnt_nxt;
            drv_o    <= drv_nxt;
            if (mchk_rise)
                exempt_r <= exempt_now;
        end
    end

    // ****************************************
    // wishbone slave
    // ****************************************
    // one wait state: ack follows the request by one edge
    wire        req     = cyc_i & stb_i & ~ack_o;
    wire        hit_ctl = (adr_i == CTRL_OFS);
    wire        hit_st  = (adr_i == STAT_OFS);
    wire        hit_cnt = (adr_i == CNT_OFS);
    wire        wr_ctl  = req & we_i & hit_ctl & sel_i[0];

    wire [ST_W-1:0] stat_v;
    assign stat_v[ST_PASS]  = pass_r;
    assign stat_v[ST_RELAY] = drv_o.meter_drive_relay;
    assign stat_v[ST_PROC]  = drv_o.proc_meter;
    assign stat_v[ST_MAINT] = drv_o.maint_meter;
    assign stat_v[ST_RUN]   = drv_o.cpu_running;
    assign stat_v[ST_SUPP]  = suppress;

    // unmapped addresses acknowledge and read zero
    wire [31:0] rd_mux  = hit_ctl ? {30'h0, ctrl_r}            :
                          hit_st  ? {{(32-ST_W){1'b0}}, stat_v} :
                          hit_cnt ? {{(32-CNT_W){1'b0}}, cnt_r} :
                          32'h0;

    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            ctrl_r <= CTRL_RST;
            ack_o  <= 1'b0;
            dat_o  <= 32'h0;
        end
        else if (ce_i)
        begin
            ack_o <= req;
            if (req & ~we_i)
                dat_o <= rd_mux;
            if (wr_ctl)
                ctrl_r <= dat_i[1:0];
        end
    end

    // ****************************************
    // assertions
    // ****************************************
    sequence trig_event_s;
        ce_i && trig_set;
    endsequence

    sequence pulse_gated_s;
        ce_i && trig_clr && !trig_set;
    endsequence

    meter_select_a: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        ce_i && relay_nxt && !pin.key_maint
        |=> drv_o.proc_meter && !drv_o.maint_meter)
        else $error("process meter not selected");

    maint_select_a: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        ce_i && relay_nxt && pin.key_maint
        |=> drv_o.maint_meter && !drv_o.proc_meter)
        else $error("maintenance meter not selected");

    run_gate_a: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        ce_i && run_req |=> drv_o.meter_drive_relay
            && cnt_r == RELOAD)
        else $error("run request did not drive meter");

    button_pulse_a: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        ce_i && pin.manual && ctrl_r[CTRL_EN] && !run_req
        && pb_rise == (PB_W'(1) << STOP_IDX)
        |=> cnt_r == $past(cnt_r) - CNT_W'(($past(cnt_r) != 0)))
        else $error("stop while manual pulsed meter");

    trig_set_a: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        trig_event_s |=> pass_r)
        else $error("pass trigger not set");

    single_clear_a: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        pulse_gated_s |=> !pass_r)
        else $error("pass trigger not cleared");

    check_stop_a: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        pin.machine_check && !exempt |-> !run_req
            && !drv_nxt.cpu_running)
        else $error("recording during machine check");

    ipl_exempt_a: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        ce_i && mchk_rise && pin.initial_program_load
        && pin.check_disable_position |=> exempt_r)
        else $error("load-time check exemption lost");

    hold_exempt_a: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        ce_i && mchk_rise && !pin.initial_program_load
        && pin.stor_hold |=> exempt_r)
        else $error("storage hold exemption lost");

    cpu_running_a: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        ce_i && (pin.wait_state || pin.manual || suppress)
        |=> !drv_o.cpu_running)
        else $error("running shown while stopped");

    proc_time_a: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        $rose(drv_o.proc_meter) |-> drv_o.meter_out)
        else $error("process time not indicated");

    stretch_hold_a: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        ce_i && cnt_r > CNT_W'(1) |=> drv_o.meter_drive_relay
            && cnt_r != '0)
        else $error("meter dropped before minimum");

    relay_count_a: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        drv_o.meter_drive_relay == (cnt_r != '0))
        else $error("relay does not follow counter");

    ack_once_a: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        ack_o |=> !ack_o)
        else $error("ack held two cycles");

endmodule

// ---- umc_top_tb.sv ----
`timescale 1ns/100ps
module umc_top_tb;
    import umc_pkg::*;
    // short stretch so each decay costs a few dozen cycles
    localparam int MC    = 20;
    localparam int LIMIT = 20000;
    // {key, wait, manual, io} then {proc, maint, relay, running, out}
    localparam logic [8:0] ROWS [6] = '{9'h017, 9'h10e, 9'h080,
                                        9'h040, 9'h0b5, 9'h16c};
    // {ipl, check disable, storage hold, recording expected}
    localparam logic [3:0] MCK [4] = '{4'h0, 4'hd, 4'ha, 4'h3};

    logic        clk_i;
    logic        sys_rst_i;
    logic        cyc_i;
    logic        stb_i;
    logic        we_i;
    logic        io_busy_r;
    logic        ce_r;
    logic        ack_o;
    logic        meter_in;
    logic [3:0]  adr_i;
    logic [31:0] dat_i;
    logic [31:0] dat_o;
    logic [31:0] rd;
    logic [15:0] unit_time;
    umc_pins_s   pins_r;
    umc_pins_s   pins;
    umc_drv_s    drv_o;
    int          n_mismatch = 0;
    int          cmp_count = 0;
    int          tick = 0;

    umc_top #(.MIN_CYC(MC)) dut (
        .clk_i(clk_i), .sys_rst_i(sys_rst_i), .ce_i(ce_r),
        .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
        .sel_i(4'h1), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .pins_i(pins), .drv_o(drv_o));

    umc_chan_model chan (
        .clk_i(clk_i), .sys_rst_i(sys_rst_i), .io_busy_i(io_busy_r),
        .cpu_running_i(drv_o.cpu_running), .meter_out_i(drv_o.meter_out),
        .meter_in_o(meter_in), .unit_time_o(unit_time));

    always_comb
    begin
        pins = pins_r;
        pins.meter_in = meter_in;
    end

    initial
    begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end

    // ****************************************
    // helpers
    // ****************************************
    task results();
        $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    always @(posedge clk_i)
    begin
        tick <= tick + 1;
        if (tick == LIMIT)
        begin
            n_mismatch++;
            results();
        end
    end

    task chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    task clk_n(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    // one classic cycle; entered just after a rising edge
    task wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        @(posedge clk_i);
        while (ack_o !== 1'b1)
            @(posedge clk_i);
        rd = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
        @(posedge clk_i);
    endtask

    // held four cycles so the two-flop synchroniser cannot miss it;
    // waits one edge first so field updates from setp have landed
    task pulse(input umc_pins_s m);
        clk_n(1);
        pins_r <= pins_r | m;
        clk_n(4);
        pins_r <= pins_r & ~m;
        clk_n(6);
    endtask

    task setp(input logic k, input logic w, input logic m, input logic io);
        pins_r.key_maint <= k;
        pins_r.wait_state <= w;
        pins_r.manual <= m;
        io_busy_r <= io;
    endtask

    // ****************************************
    // sequence
    // ****************************************
    initial
    begin
        umc_pins_s m;
        sys_rst_i = 1'b1;
        cyc_i = 1'b0;
        stb_i = 1'b0;
        we_i = 1'b0;
        adr_i = 4'h0;
        dat_i = 32'h0;
        io_busy_r = 1'b0;
        ce_r = 1'b1;
        pins_r = '0;
        clk_n(2);
        chk(drv_o, 32'h0);
        sys_rst_i <= 1'b0;
        clk_n(1);
        wb(1'b0, CTRL_OFS, 32'h0);
        chk(rd, 32'h1);
        wb(1'b0, CNT_OFS, 32'h0);
        chk(rd, 32'h0);
        wb(1'b1, 4'hc, 32'hffff_ffff);
        wb(1'b0, 4'hc, 32'h0);
        chk(rd, 32'h0);
        wb(1'b0, CTRL_OFS, 32'h0);
        chk(rd, 32'h1);
        setp(1'b0, 1'b1, 1'b0, 1'b0);
        m = '0;
        m.start_op = 1'b1;
        pulse(m);
        wb(1'b0, STAT_OFS, 32'h0);
        chk(rd[ST_PASS], 32'h1);
        for (int i = 0; i < 6; i++)
        begin
            setp(ROWS[i][8], ROWS[i][7], ROWS[i][6], ROWS[i][5]);
            clk_n(8);
            chk(drv_o, ROWS[i][4:0]);
            setp(1'b0, 1'b1, 1'b0, 1'b0);
            clk_n(MC + 10);
            chk(drv_o, 32'h0);
        end
        // measure how long the relay outlives its request
        setp(1'b0, 1'b0, 1'b0, 1'b0);
        clk_n(8);
        setp(1'b0, 1'b1, 1'b0, 1'b0);
        clk_n(1);
        for (int k = 0; k <= MC + 8; k++)
            if (drv_o.meter_drive_relay !== 1'b1 || k == MC + 8)
            begin
                chk(k >= MC && k <= MC + 6, 32'h1);
                break;
            end
            else
                clk_n(1);
        // enable low freezes the stretch counter and the drives
        setp(1'b0, 1'b0, 1'b0, 1'b0);
        clk_n(8);
        ce_r <= 1'b0;
        setp(1'b0, 1'b1, 1'b0, 1'b0);
        clk_n(MC + 10);
        chk(drv_o.meter_drive_relay, 32'h1);
        ce_r <= 1'b1;
        clk_n(MC + 10);
        chk(drv_o.meter_drive_relay, 32'h0);
        setp(1'b0, 1'b1, 1'b1, 1'b0);
        clk_n(MC + 10);
        for (int i = 0; i < PB_W; i++)
        begin
            m = '0;
            m.pushbutton[i] = 1'b1;
            pulse(m);
            chk(drv_o.meter_drive_relay, i != STOP_IDX);
            clk_n(MC + 10);
        end
        setp(1'b0, 1'b1, 1'b0, 1'b0);
        m = '0;
        m.pushbutton[STOP_IDX] = 1'b1;
        pulse(m);
        chk(drv_o.meter_drive_relay, 32'h1);
        clk_n(MC + 10);
        for (int i = 0; i < 4; i++)
        begin
            setp(1'b0, 1'b0, 1'b0, 1'b0);
            pins_r.initial_program_load <= MCK[i][3];
            pins_r.check_disable_position <= MCK[i][2];
            pins_r.stor_hold <= MCK[i][1];
            clk_n(8);
            pins_r.machine_check <= 1'b1;
            clk_n(MC + 10);
            chk({drv_o.meter_drive_relay, drv_o.cpu_running},
                {2{MCK[i][0]}});
            pins_r.machine_check <= 1'b0;
            setp(1'b0, 1'b1, 1'b0, 1'b0);
            clk_n(MC + 10);
        end
        // meter disabled: no drive, but the running indication stays
        wb(1'b1, CTRL_OFS, 32'h0);
        setp(1'b0, 1'b0, 1'b0, 1'b0);
        clk_n(8);
        chk(drv_o, 32'h2);
        setp(1'b0, 1'b1, 1'b0, 1'b0);
        wb(1'b1, CTRL_OFS, 32'h3);
        m = '0;
        m.clk_pulse = 1'b1;
        pulse(m);
        wb(1'b0, STAT_OFS, 32'h0);
        chk(rd[ST_PASS], 32'h0);
        for (int i = 0; i < 3; i++)
        begin
            m = '0;
            case (i)
                0: m.start_op = 1'b1;
                1: m.load_op = 1'b1;
                default: m.reset_op = 1'b1;
            endcase
            pulse(m);
            wb(1'b0, STAT_OFS, 32'h0);
            chk(rd[ST_PASS], 32'h1);
            m = '0;
            m.clk_pulse = 1'b1;
            pulse(m);
            wb(1'b0, STAT_OFS, 32'h0);
            chk(rd[ST_PASS], 32'h0);
        end
        chk(unit_time != 16'h0000, 32'h1);
        sys_rst_i <= 1'b1;
        clk_n(2);
        chk(drv_o, 32'h0);
        sys_rst_i <= 1'b0;
        clk_n(1);
        wb(1'b0, CTRL_OFS, 32'h0);
        chk(rd, 32'h1);
        results();
    end
endmodule
